//--- inc/rpt_xmit_pkg.sv
// Constants shared by the buffered serial word transmitter and its FIFO.
// Assumes a 16-bit host I/O bus with word-addressed memory and a one-bit serial link.
package rpt_xmit_pkg;
   localparam logic [5:0] DEV_CODE = 6'h24;
   localparam int unsigned MASK_BIT = 11;
   localparam int unsigned WORD_W = 16;
   localparam int unsigned DATA_W = 12;
   localparam int unsigned FIFO_DEPTH = 4;
   localparam int unsigned PAR_SEL_POS = 0;
   localparam int unsigned DATA_LSB = 4;
   localparam logic [15:0] ADDR_RESET = 16'h0000;
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   // Idle character: parity selector 1 and all twelve data bits set
   localparam logic [11:0] IDLE_DATA = 12'hfff;
   localparam logic IDLE_PSEL = 1'b1;
   // Character frame: start bit, 12 data bits, parity bit, stop bit
   localparam int unsigned FRAME_BITS = 15;
   localparam int unsigned BIT_TIME_NS = 1000;
   localparam int unsigned CLK_PERIOD_NS = 4;
   localparam int unsigned BIT_CYCLES = BIT_TIME_NS / CLK_PERIOD_NS;
endpackage

//--- inc/word_stream_if.sv
// Valid/ready word carrier between the fetch side and the FIFO.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface word_stream_if #(parameter int W = 16);
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

//--- rtl/word_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ps
module word_fifo
   import rpt_xmit_pkg::*;
#(
   parameter int W = 16,
   parameter int DEPTH = 4
) (
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   input wire logic flush_i,
   word_stream_if.snk in_s,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [W-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   // Refused at elaboration: pointer wrap relies on a power-of-two depth
   if (W < 1 || DEPTH < 2 || (1 << AW) != DEPTH) begin
      $error("DEPTH must be a power of two of at least 2");
   end
   logic [W-1:0] mem_r [DEPTH];
   logic [W-1:0] mem_nxt [DEPTH];
   logic [AW:0] wp_r, wp_nxt, rp_r, rp_nxt;
   logic full, empty, push, pop;

   // Honest flags from pointer difference
   assign empty = (wp_r == rp_r);
   assign full = (wp_r[AW-1:0] == rp_r[AW-1:0]) && (wp_r[AW] != rp_r[AW]);
   assign in_s.ready = !full && !flush_i;
   assign out_valid_o = !empty;
   assign out_data_o = mem_r[rp_r[AW-1:0]];
   assign push = in_s.valid && in_s.ready;
   assign pop = out_valid_o && out_ready_i;

   // Next pointers and storage
   always_comb begin
      mem_nxt = mem_r;
      wp_nxt = wp_r;
      rp_nxt = rp_r;
      if (flush_i) begin
         rp_nxt = wp_r;
      end else begin
         if (push) begin
            mem_nxt[wp_r[AW-1:0]] = in_s.data;
            wp_nxt = wp_r + 1'b1;
         end
         if (pop) begin
            rp_nxt = rp_r + 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wp_r <= '0;
         rp_r <= '0;
         for (int i = 0; i < DEPTH; i++) mem_r[i] <= '0;
      end else begin
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
         mem_r <= mem_nxt;
      end
   end
endmodule

//--- rtl/rpt_xmit.sv
// Buffered serial word transmitter: DMA fetch of 16-bit words, serial send.
// Assumes a host I/O bus with decoded device code, a word-wide DMA port
// answering with a one-cycle ack, and a free-running serial line.
`timescale 1ns/1ps
module rpt_xmit
   import rpt_xmit_pkg::*;
#(
   parameter int BIT_CYC = BIT_CYCLES
) (
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   input wire logic [5:0] dev_sel_i,
   input wire logic start_i,
   input wire logic clear_i,
   input wire logic io_reset_i,
   input wire logic doa_i,
   input wire logic dob_i,
   input wire logic dia_i,
   input wire logic [15:0] bus_data_i,
   input wire logic [15:0] mask_i,
   input wire logic intr_ack_i,
   output logic [15:0] bus_data_o,
   output logic bus_data_oe_o,
   output logic busy_o,
   output logic done_o,
   output logic intr_req_o,
   output logic dma_req_o,
   output logic [15:0] dma_addr_o,
   input wire logic dma_ack_i,
   input wire logic [15:0] dma_data_i,
   output logic serial_o
);
   // Refused at elaboration: the bit divider needs at least one cycle
   if (BIT_CYC < 1) begin
      $error("BIT_CYC must be at least 1");
   end

   typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_DRAIN} xfer_state_t;
   xfer_state_t state_r, state_nxt;
   logic [15:0] addr_r, addr_nxt, cnt_r, cnt_nxt, rd_r, rd_nxt;
   logic rd_oe_r, rd_oe_nxt, done_r, done_nxt;
   logic sel, abort;
   logic fifo_valid, fifo_ready;
   logic ser_busy_r, ser_busy_nxt, tick; // Early: completion waits on the line
   logic [15:0] fifo_data;
   word_stream_if #(.W(WORD_W)) fetch_s ();

   assign sel = (dev_sel_i == DEV_CODE);
   assign abort = (sel && clear_i) || io_reset_i;

   // Fetch side: a word is only requested while the FIFO can take it
   assign dma_req_o = (state_r == ST_FETCH) && fetch_s.ready;
   assign dma_addr_o = addr_r;
   assign fetch_s.valid = (state_r == ST_FETCH) && dma_ack_i;
   assign fetch_s.data = dma_data_i;

   word_fifo #(.W(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .ref_clk_i(ref_clk_i),
      .reset_n_i(reset_n_i),
      .flush_i(abort),
      .in_s(fetch_s),
      .out_valid_o(fifo_valid),
      .out_ready_i(fifo_ready),
      .out_data_o(fifo_data)
   );

   // Register loads, DMA progress and completion
   always_comb begin
      state_nxt = state_r;
      addr_nxt = addr_r;
      cnt_nxt = cnt_r;
      rd_nxt = rd_r;
      rd_oe_nxt = 1'b0;
      done_nxt = done_r;
      if (sel && doa_i) addr_nxt = bus_data_i;
      if (sel && dob_i) cnt_nxt = bus_data_i;
      if (sel && dia_i) begin
         rd_nxt = {addr_r[15:1], 1'b0};
         rd_oe_nxt = 1'b1;
      end
      if (sel && intr_ack_i) done_nxt = 1'b0;
      case (state_r)
         ST_IDLE: begin
            if (sel && start_i) begin
               done_nxt = 1'b0;
               state_nxt = (cnt_r == 16'h0000) ? ST_DRAIN : ST_FETCH;
            end
         end
         ST_FETCH: begin
            if (fetch_s.valid && fetch_s.ready) begin
               addr_nxt = addr_r + 16'h0001;
               cnt_nxt = cnt_r + 16'h0001;
               if (cnt_r == 16'hffff) state_nxt = ST_DRAIN;
            end
         end
         ST_DRAIN: begin
            // Completion waits until the last word has left the line
            if (!fifo_valid && !ser_busy_r) begin
               state_nxt = ST_IDLE;
               done_nxt = 1'b1;
            end
         end
         default: state_nxt = ST_IDLE;
      endcase
      if (abort) begin
         state_nxt = ST_IDLE;
         done_nxt = 1'b0;
      end
   end

   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state_r <= ST_IDLE;
         addr_r <= ADDR_RESET;
         cnt_r <= COUNT_RESET;
         rd_r <= 16'h0000;
         rd_oe_r <= 1'b0;
         done_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         addr_r <= addr_nxt;
         cnt_r <= cnt_nxt;
         rd_r <= rd_nxt;
         rd_oe_r <= rd_oe_nxt;
         done_r <= done_nxt;
      end
   end

   assign bus_data_o = rd_r;
   assign bus_data_oe_o = rd_oe_r;
   assign busy_o = (state_r != ST_IDLE);
   assign done_o = done_r;
   assign intr_req_o = done_r && !mask_i[MASK_BIT];

   // Serial side: bit-rate enable, frame shifter
   logic [$clog2(BIT_CYC+1)-1:0] div_r, div_nxt;
   logic [FRAME_BITS-1:0] shf_r, shf_nxt;
   logic [3:0] bit_r, bit_nxt;
   logic [11:0] chr_data;
   logic chr_psel, par;

   assign tick = (div_r == '0);
   // Idle characters whenever no buffer word is waiting
   assign chr_data = fifo_valid ? fifo_data[DATA_LSB +: DATA_W] : IDLE_DATA;
   assign chr_psel = fifo_valid ? fifo_data[PAR_SEL_POS] : IDLE_PSEL;
   // Odd parity makes the ones count odd; even parity makes it even
   assign par = (^chr_data) ^ ~chr_psel;
   // Word boundary only; no message structure is looked at
   assign fifo_ready = tick && !ser_busy_r;

   always_comb begin
      div_nxt = tick ? ($bits(div_r))'(BIT_CYC - 1) : div_r - 1'b1;
      shf_nxt = shf_r;
      bit_nxt = bit_r;
      ser_busy_nxt = ser_busy_r;
      if (tick) begin
         if (!ser_busy_r) begin
            // Frame, LSB first: start 0, data, parity, stop 1
            shf_nxt = {1'b1, par, chr_data, 1'b0};
            bit_nxt = 4'(FRAME_BITS - 1);
            ser_busy_nxt = 1'b1;
         end else begin
            shf_nxt = {1'b1, shf_r[FRAME_BITS-1:1]};
            bit_nxt = bit_r - 4'h1;
            if (bit_r == 4'h0) ser_busy_nxt = 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         div_r <= '0;
         shf_r <= '1;
         bit_r <= 4'h0;
         ser_busy_r <= 1'b0;
      end else begin
         div_r <= div_nxt;
         shf_r <= shf_nxt;
         bit_r <= bit_nxt;
         ser_busy_r <= ser_busy_nxt;
      end
   end

   assign serial_o = ser_busy_r ? shf_r[0] : 1'b1;

   // Checks
   sequence s_fetch_ack;
      state_r == ST_FETCH && dma_ack_i && fetch_s.ready;
   endsequence
   property p_addr_step;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      s_fetch_ack and !abort and !(sel && doa_i) |=> addr_r == $past(addr_r) + 16'h0001;
   endproperty
   a_addr_step: assert property (p_addr_step) else $error("address did not step");
   property p_abort;
      @(posedge ref_clk_i) disable iff (!reset_n_i) abort |=> state_r == ST_IDLE && !done_r;
   endproperty
   a_abort: assert property (p_abort) else $error("clear did not abort");
   property p_ioreset;
      @(posedge ref_clk_i) disable iff (!reset_n_i) io_reset_i |=> !busy_o;
   endproperty
   a_ioreset: assert property (p_ioreset) else $error("io reset not a clear");
   property p_start;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      sel && start_i && state_r == ST_IDLE && !abort && cnt_r != 16'h0000 |=> state_r == ST_FETCH;
   endproperty
   a_start: assert property (p_start) else $error("start ignored");
   property p_rd;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      sel && dia_i |=> bus_data_oe_o && bus_data_o == {$past(addr_r[15:1]), 1'b0};
   endproperty
   a_rd: assert property (p_rd) else $error("address read wrong");
   property p_doa;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      sel && doa_i && state_r == ST_IDLE |=> addr_r == $past(bus_data_i);
   endproperty
   a_doa: assert property (p_doa) else $error("start address not stored");
   property p_dob;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      sel && dob_i && state_r == ST_IDLE |=> cnt_r == $past(bus_data_i);
   endproperty
   a_dob: assert property (p_dob) else $error("count not stored");
   property p_last;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      s_fetch_ack and cnt_r == 16'hffff and !abort |=> state_r == ST_DRAIN;
   endproperty
   a_last: assert property (p_last) else $error("count end missed");
   property p_par;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      tick && !ser_busy_r |=> ^shf_r[13:1] == !$past(chr_psel);
   endproperty
   a_par: assert property (p_par) else $error("parity wrong");
   property p_idle;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      tick && !ser_busy_r && !fifo_valid |=> shf_r[12:1] == IDLE_DATA;
   endproperty
   a_idle: assert property (p_idle) else $error("idle char not sent");
   property p_intr;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      state_r == ST_DRAIN && state_nxt == ST_IDLE && !abort ##1 !mask_i[MASK_BIT] |-> intr_req_o;
   endproperty
   a_intr: assert property (p_intr) else $error("no completion interrupt");

   // Fetch, count and bus read checks
   property p_cnt_step;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      s_fetch_ack and !abort |=> cnt_r == $past(cnt_r) + 16'h0001;
   endproperty
   a_cnt_step: assert property (p_cnt_step) else $error("count did not step");
   property p_start_busy;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      sel && start_i && state_r == ST_FETCH && !abort && cnt_r != 16'hffff
      |=> state_r == ST_FETCH && !done_r;
   endproperty
   a_start_busy: assert property (p_start_busy) else $error("start not ignored");
   property p_zero_count;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      sel && start_i && state_r == ST_IDLE && !abort && cnt_r == 16'h0000 |=> state_r == ST_DRAIN;
   endproperty
   a_zero_count: assert property (p_zero_count) else $error("empty buffer not done");
   // A clear must also drop words already fetched, not only stop fetching
   property p_flush;
      @(posedge ref_clk_i) disable iff (!reset_n_i) abort |=> !fifo_valid;
   endproperty
   a_flush: assert property (p_flush) else $error("words survived a clear");
   property p_oe_once;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      bus_data_oe_o && !(sel && dia_i) |=> !bus_data_oe_o;
   endproperty
   a_oe_once: assert property (p_oe_once) else $error("read data held too long");

   // Completion checks
   sequence s_drain_end;
      state_r == ST_DRAIN && !fifo_valid && !ser_busy_r && !abort;
   endsequence
   property p_done_set;
      @(posedge ref_clk_i) disable iff (!reset_n_i) s_drain_end |=> done_r && !busy_o;
   endproperty
   a_done_set: assert property (p_done_set) else $error("completion not flagged");
   property p_done_hold;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      done_r && !abort && !(sel && intr_ack_i) && !(sel && start_i) |=> done_r;
   endproperty
   a_done_hold: assert property (p_done_hold) else $error("done flag dropped");

   // Serial line checks
   property p_frame_start;
      @(posedge ref_clk_i) disable iff (!reset_n_i) tick && !ser_busy_r |=> !serial_o;
   endproperty
   a_frame_start: assert property (p_frame_start) else $error("frame did not open");
   property p_word;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      tick && !ser_busy_r && fifo_valid
      |=> shf_r[12:1] == $past(fifo_data[DATA_LSB +: DATA_W]);
   endproperty
   a_word: assert property (p_word) else $error("word data not framed");
endmodule

//--- verif/dma_mem_model.sv
// Host memory model answering the transmitter's fetches.
// Assumes the bench sets the answer delay; each word derives from its address.
`timescale 1ns/1ps
module dma_mem_model (
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   input wire logic req_i,
   input wire logic [15:0] addr_i,
   input wire logic [3:0] delay_i,
   output logic ack_o,
   output logic [15:0] data_o
);
   logic [3:0] wait_r;
   // Answer after delay_i cycles; data is scrambled outside the ack cycle
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wait_r <= 4'h0;
         ack_o <= 1'b0;
         data_o <= 16'h0000;
      end else if (req_i && !ack_o && wait_r >= delay_i) begin
         ack_o <= 1'b1;
         wait_r <= 4'h0;
         // An address with low twelve bits zero yields the idle character
         data_o <= {~addr_i[11:0], 3'h0, ~addr_i[0]};
      end else begin
         ack_o <= 1'b0;
         wait_r <= req_i ? wait_r + 4'h1 : 4'h0;
         data_o <= ~data_o; // No stale word for the design to reuse
      end
   end
endmodule

//--- verif/rpt_xmit_bench.sv
// Self-checking bench for the serial word transmitter.
// Assumes a bit time of two clocks; serial frames are decoded at falling edges.
`timescale 1ns/1ps
module rpt_xmit_bench
   import rpt_xmit_pkg::*;
;
   logic ref_clk_i = 1'b0, reset_n_i = 1'b0, start_i = 1'b0, clear_i = 1'b0;
   logic io_reset_i = 1'b0, doa_i = 1'b0, dob_i = 1'b0, dia_i = 1'b0, intr_ack_i = 1'b0;
   logic [5:0] dev_sel_i = 6'h00;
   logic [15:0] bus_data_i = 16'h0000, mask_i = 16'h0000, bus_data_o, dma_addr_o, dma_data_i;
   logic bus_data_oe_o, busy_o, done_o, intr_req_o, dma_req_o, dma_ack_i, serial_o;
   logic [3:0] delay = 4'h3;
   logic [14:0] fr;
   logic [14:0] rx_q[$];
   int bad_count = 0, n_tests = 0, cycles = 0, k_w = 0;
   logic [15:0] exp_w;

   rpt_xmit #(.BIT_CYC(2)) dut_u (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
      .dev_sel_i(dev_sel_i), .start_i(start_i), .clear_i(clear_i), .io_reset_i(io_reset_i),
      .doa_i(doa_i), .dob_i(dob_i), .dia_i(dia_i), .bus_data_i(bus_data_i), .mask_i(mask_i),
      .intr_ack_i(intr_ack_i), .bus_data_o(bus_data_o), .bus_data_oe_o(bus_data_oe_o),
      .busy_o(busy_o), .done_o(done_o), .intr_req_o(intr_req_o), .dma_req_o(dma_req_o),
      .dma_addr_o(dma_addr_o), .dma_ack_i(dma_ack_i), .dma_data_i(dma_data_i),
      .serial_o(serial_o));
   dma_mem_model mem_u (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .req_i(dma_req_o),
      .addr_i(dma_addr_o), .delay_i(delay), .ack_o(dma_ack_i), .data_o(dma_data_i));

   initial begin
      forever #2 ref_clk_i = ~ref_clk_i;
   end
   // Hang guard, well above the longest scenario
   always @(posedge ref_clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         give_verdict();
      end
   end
   // Line receiver: start bit found, then one sample per bit
   initial begin
      forever begin
         @(negedge ref_clk_i);
         if (serial_o === 1'b0) begin
            for (int i = 0; i < 15; i++) begin
               fr[i] = serial_o;
               if (i < 14) repeat (2) @(negedge ref_clk_i);
            end
            rx_q.push_back(fr);
         end
      end
   end

   function automatic logic [14:0] frame_of(input logic [15:0] w);
      return {1'b1, ^w[15:4] ^ ~w[0], w[15:4], 1'b0};
   endfunction
   function automatic logic [15:0] mem_word(input logic [15:0] a);
      return {~a[11:0], 3'h0, ~a[0]};
   endfunction
   // Idle frames are skipped, since gaps may be filled with them
   function automatic int n_data();
      int n = 0;
      foreach (rx_q[i]) n += int'(rx_q[i] !== frame_of({IDLE_DATA, 3'h0, IDLE_PSEL}));
      return n;
   endfunction

   task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // One bus pulse: 0 doa, 1 dob, 2 start, 3 clear, 4 io reset, 5 intr ack
   task bus(input logic [5:0] sel, input int k, input logic [15:0] d);
      @(negedge ref_clk_i);
      dev_sel_i = sel;
      bus_data_i = d;
      {intr_ack_i, io_reset_i, clear_i, start_i, dob_i, doa_i} = 6'h01 << k;
      @(negedge ref_clk_i);
      {intr_ack_i, io_reset_i, clear_i, start_i, dob_i, doa_i} = 6'h00;
   endtask
   task rd(input logic [15:0] exp);
      @(negedge ref_clk_i);
      dev_sel_i = DEV_CODE;
      dia_i = 1'b1;
      @(negedge ref_clk_i);
      dia_i = 1'b0;
      chk("oe", {15'h0, bus_data_oe_o}, 16'h0001);
      chk("addr", bus_data_o, exp);
   endtask
   task wait_done();
      for (int i = 0; i < 2000 && done_o !== 1'b1; i++) @(negedge ref_clk_i);
      chk("done", {15'h0, done_o}, 16'h0001);
   endtask
   task give_verdict();
      if (bad_count == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   initial begin
      repeat (12) @(posedge ref_clk_i);
      @(negedge ref_clk_i);
      reset_n_i = 1'b1;
      chk("rst", {11'h0, busy_o, done_o, intr_req_o, dma_req_o, serial_o}, 16'h0001);
      repeat (100) @(negedge ref_clk_i);
      chk("idle", 16'(n_data() + (rx_q.size() == 0)), 16'h0000);
      // Three words from an odd address, slow memory
      bus(DEV_CODE, 0, 16'h0103);
      bus(DEV_CODE, 1, 16'hfffd);
      rd(16'h0102);
      rx_q.delete();
      bus(DEV_CODE, 2, 16'h0000);
      chk("busy", {15'h0, busy_o}, 16'h0001);
      wait_done();
      chk("intr", {15'h0, intr_req_o}, 16'h0001);
      chk("words", 16'(n_data()), 16'h0003);
      for (int i = 0; i < rx_q.size(); i++) begin
         if (rx_q[i] !== frame_of({IDLE_DATA, 3'h0, IDLE_PSEL})) begin
            exp_w = mem_word(16'h0103 + 16'(k_w));
            chk("frame", {1'b0, rx_q[i]}, {1'b0, frame_of(exp_w)});
            k_w++;
         end
      end
      rd(16'h0106);
      bus(DEV_CODE, 5, 16'h0000);
      chk("ack", {15'h0, done_o}, 16'h0000);
      bus(6'h25, 0, 16'h0200);
      rd(16'h0106);
      // One word with the interrupt masked, then unmasked
      delay = 4'h0;
      mask_i = 16'h0800;
      bus(DEV_CODE, 0, 16'h1000);
      bus(DEV_CODE, 1, 16'hffff);
      bus(DEV_CODE, 2, 16'h0000);
      wait_done();
      chk("mask", {15'h0, intr_req_o}, 16'h0000);
      mask_i = 16'h0000;
      @(negedge ref_clk_i);
      chk("unmask", {15'h0, intr_req_o}, 16'h0001);
      bus(DEV_CODE, 5, 16'h0000);
      // Abort by clear, then by bus reset from another selected code
      delay = 4'h3;
      for (int k = 3; k < 5; k++) begin
         bus(DEV_CODE, 1, 16'hfff0);
         bus(DEV_CODE, 2, 16'h0000);
         repeat (20) @(negedge ref_clk_i);
         chk("run", {15'h0, busy_o}, 16'h0001);
         bus(DEV_CODE, 2, 16'h0000);
         chk("restart", {15'h0, busy_o}, 16'h0001);
         bus(k == 3 ? DEV_CODE : 6'h00, k, 16'h0000);
         for (int i = 0; i < 100 && busy_o !== 1'b0; i++) @(negedge ref_clk_i);
         chk("abort", {14'h0, busy_o, done_o}, 16'h0000);
         repeat (40) @(negedge ref_clk_i);
         rx_q.delete();
         repeat (100) @(negedge ref_clk_i);
         chk("after", 16'(n_data()), 16'h0000);
      end
      // Zero count completes without a fetch, once the frame on the line ends
      bus(DEV_CODE, 1, 16'h0000);
      bus(DEV_CODE, 2, 16'h0000);
      wait_done();
      give_verdict();
   end
endmodule
